// file: core/ues_classify.sv
// Purpose: turn per-class events into fatal and non-fatal reports
// Assumes: events are one-cycle pulses on aclk
// Notes:   outputs registered, one cycle after the event
`timescale 1ns/100ps
`include "ues_defines.svh"
module ues_classify
  import ues_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Error classes
  ues_err_if.cls   err
);
  typedef struct packed {
    logic        fatal;
    logic        nonfatal;
    logic [31:0] logged;
  } ues_cls_t;

  ues_cls_t st;
  ues_cls_t next_st;
  ues_word_t live;

  always_comb begin
    live = err.event_bits & ~err.mask_bits & `UES_CLASS_MASK; // [RULE3] [RULE10]
    next_st.fatal    = |(live & err.sev_bits);                 // [RULE1]
    next_st.nonfatal = |(live & ~err.sev_bits);                // [RULE2]
    next_st.logged   = live;                                   // [RULE10]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign err.fatal    = st.fatal;
  assign err.nonfatal = st.nonfatal;
  assign err.logged   = st.logged;
endmodule : ues_classify

// file: core/ues_severity.sv
// Purpose: severity select register bank with AXI4-Lite slave and reporting
// Assumes: cold_resetn is the fundamental reset, aresetn may be a hot reset
// Notes:   unmapped addresses answer DECERR, reads of them return zero
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "ues_defines.svh"
module ues_severity
  import ues_pkg::*;
(
  // Clock and resets
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        cold_resetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Error events from the port
  input  wire logic [31:0] error_event,
  // Reports toward the root complex
  output logic             report_fatal,
  output logic             report_nonfatal,
  output logic [31:0]      report_log,
  // Interrupt
  output logic             irq
);
  // ==========================================================================
  // State
  typedef struct packed {
    ues_bus_t  bus;
    ues_word_t irq_stat;
    ues_word_t irq_mask;
  } ues_state_t;

  // Sticky part lives under the cold reset only
  typedef struct packed {
    ues_word_t uncorrectable_error_severity_select;
    ues_word_t uncorrectable_error_mask_reg;
  } ues_sticky_t;

  ues_state_t  st;
  ues_state_t  next_st;
  ues_sticky_t sk;
  ues_sticky_t next_sk;

  ues_err_if err ();

  ues_classify u_classify (
    .aclk    (aclk),
    .aresetn (aresetn),
    .err     (err)
  );

  assign err.event_bits = error_event;
  assign err.sev_bits   = sk.uncorrectable_error_severity_select;
  assign err.mask_bits  = sk.uncorrectable_error_mask_reg;

  // ==========================================================================
  // Helpers
  function automatic ues_word_t merge(input ues_word_t old, input ues_word_t val,
                                      input logic [3:0] strb);
    ues_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic ues_word_t bytemask(input logic [3:0] strb);
    ues_word_t r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = {8{strb[i]}};
    end
    return r;
  endfunction : bytemask

  function automatic logic mapped(input logic [11:0] a);
    return a == `UES_OFF_SEVERITY || a == `UES_OFF_MASK ||
           a == `UES_OFF_IRQ_STAT || a == `UES_OFF_IRQ_MASK;
  endfunction : mapped

  logic      do_write;
  logic      do_read;
  ues_word_t rd_word;
  ues_word_t events;

  assign s_axi_awready = !st.bus.aw_full;
  assign s_axi_wready  = !st.bus.w_full;
  assign s_axi_arready = !st.bus.rvalid;
  assign do_write      = st.bus.aw_full && st.bus.w_full && !st.bus.bvalid;
  assign do_read       = s_axi_arvalid && !st.bus.rvalid;

  always_comb begin
    unique case (s_axi_araddr)
      `UES_OFF_SEVERITY: rd_word =
        sk.uncorrectable_error_severity_select & `UES_WR_MASK; // [RULE7] [RULE8] [RULE11]
      `UES_OFF_MASK:     rd_word = sk.uncorrectable_error_mask_reg & `UES_WR_MASK;
      `UES_OFF_IRQ_STAT: rd_word = st.irq_stat;
      `UES_OFF_IRQ_MASK: rd_word = st.irq_mask;
      default:           rd_word = '0;
    endcase
  end

  // ==========================================================================
  // Bus and interrupt next state
  always_comb begin
    next_st = st;
    next_sk = sk;
    events  = '0;
    events[`UES_IRQ_FATAL]    = err.fatal;
    events[`UES_IRQ_NONFATAL] = err.nonfatal;

    if (s_axi_awvalid && !st.bus.aw_full) begin
      next_st.bus.aw_full = 1'b1;
      next_st.bus.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.bus.w_full) begin
      next_st.bus.w_full = 1'b1;
      next_st.bus.w_data = s_axi_wdata;
      next_st.bus.w_strb = s_axi_wstrb;
    end

    if (do_write) begin
      next_st.bus.aw_full   = 1'b0;
      next_st.bus.w_full    = 1'b0;
      next_st.bus.bvalid    = 1'b1;
      next_st.bus.bresp_err = !mapped(st.bus.aw_addr);
      unique case (st.bus.aw_addr)
        `UES_OFF_SEVERITY: next_sk.uncorrectable_error_severity_select =
          merge(sk.uncorrectable_error_severity_select, st.bus.w_data, st.bus.w_strb)
          & `UES_WR_MASK; // [RULE4] [RULE9] [RULE11]
        `UES_OFF_MASK: next_sk.uncorrectable_error_mask_reg =
          merge(sk.uncorrectable_error_mask_reg, st.bus.w_data, st.bus.w_strb) & `UES_WR_MASK;
        `UES_OFF_IRQ_STAT: next_st.irq_stat =
          st.irq_stat & ~(st.bus.w_data & bytemask(st.bus.w_strb));
        `UES_OFF_IRQ_MASK: next_st.irq_mask =
          merge(st.irq_mask, st.bus.w_data, st.bus.w_strb) & 32'h00000003;
        default: ;
      endcase
    end else if (st.bus.bvalid && s_axi_bready) begin
      next_st.bus.bvalid = 1'b0;
    end

    // Set wins over a clear in the same cycle
    next_st.irq_stat = next_st.irq_stat | events;

    if (do_read) begin
      next_st.bus.rvalid    = 1'b1;
      next_st.bus.rresp_err = !mapped(s_axi_araddr);
      next_st.bus.rdata     = rd_word;
    end else if (st.bus.rvalid && s_axi_rready) begin
      next_st.bus.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Hot reset leaves severity and mask alone
  always_ff @(posedge aclk) begin
    if (!cold_resetn) begin
      sk.uncorrectable_error_severity_select <= `UES_SEV_RESET; // [RULE5] [RULE6] [RULE12]
      sk.uncorrectable_error_mask_reg        <= '0;
    end else begin
      sk <= next_sk;                                            // [RULE12]
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_bvalid    = st.bus.bvalid;
  assign s_axi_bresp     = st.bus.bresp_err ? 2'h3 : 2'h0;
  assign s_axi_rvalid    = st.bus.rvalid;
  assign s_axi_rdata     = st.bus.rdata;
  assign s_axi_rresp     = st.bus.rresp_err ? 2'h3 : 2'h0;
  assign report_fatal    = err.fatal;                           // [RULE1]
  assign report_nonfatal = err.nonfatal;                        // [RULE2]
  assign report_log      = err.logged;                          // [RULE10]
  assign irq             = |(st.irq_stat & st.irq_mask);
endmodule : ues_severity

// file: pkg/ues_defines.svh
// Purpose: constants for the uncorrectable error severity block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   severity register at its printed offset, extra registers nearby
//
// Behaviour
// [RULE1] Unmasked event with severity one is reported as fatal.
// [RULE2] Unmasked event with severity zero is reported as non-fatal uncorrectable.
// [RULE3] Severity only matters when the class mask bit is clear.
// [RULE4] Severity bits sit at 4, 5, 12, 13, 16, 17, 18, 19, 20.
// [RULE5] Link protocol, surprise down, flow control, overflow, malformed reset to one.
// [RULE6] Poisoned, unexpected completion, end-to-end CRC, unsupported request reset to zero.
// [RULE7] Bit 14 completion time-out is read-only zero.
// [RULE8] Bit 15 completer abort is read-only zero.
// [RULE9] Bit 0 is writable sticky storage, resets zero, no reporting effect.
// [RULE10] Masked classes are neither logged nor reported.
// [RULE11] Reserved bits read zero and ignore writes.
// [RULE12] Writable bits are sticky: only a cold reset restores defaults.
`ifndef UES_DEFINES_SVH
`define UES_DEFINES_SVH

// ==========================================================================
// Register offsets
`define UES_OFF_SEVERITY 12'h10C
`define UES_OFF_MASK     12'h108
`define UES_OFF_IRQ_STAT 12'h120
`define UES_OFF_IRQ_MASK 12'h124

// ==========================================================================
// Severity field layout and defaults
`define UES_WR_MASK      32'h001F3031
`define UES_CLASS_MASK   32'h001F3030
`define UES_SEV_RESET    32'h00062030

// ==========================================================================
// Interrupt status bits
`define UES_IRQ_FATAL    0
`define UES_IRQ_NONFATAL 1

`endif

// file: pkg/ues_err_if.sv
// Purpose: per-class error signals between classifier and register bank
// Assumes: single clock
// Notes:   none
`timescale 1ns/100ps
interface ues_err_if;
  logic [31:0] event_bits;
  logic [31:0] sev_bits;
  logic [31:0] mask_bits;
  logic        fatal;
  logic        nonfatal;
  logic [31:0] logged;

  modport bank (output sev_bits, output mask_bits, output event_bits,
                input fatal, input nonfatal, input logged);
  modport cls  (input sev_bits, input mask_bits, input event_bits,
                output fatal, output nonfatal, output logged);
endinterface : ues_err_if

// file: pkg/ues_pkg.sv
// Purpose: types for the uncorrectable error severity block
// Assumes: nothing beyond the defines header
// Notes:   none
package ues_pkg;
  typedef logic [31:0] ues_word_t;

  typedef struct packed {
    logic        aw_full;
    logic [11:0] aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic        bresp_err;
    logic        rvalid;
    logic        rresp_err;
    logic [31:0] rdata;
  } ues_bus_t;
endpackage : ues_pkg

// file: verif/ues_rc_model.sv
// Purpose: root complex side, counts received error reports
// Assumes: each report is a one-cycle pulse
// Notes:   both kinds may arrive in one cycle
`timescale 1ns/100ps
module ues_rc_model (
  // Clock
  input wire logic aclk,
  // Reports
  input wire logic report_fatal,
  input wire logic report_nonfatal,
  // Counts
  output int       n_fatal,
  output int       n_nonfatal
);
  initial begin
    n_fatal = 0;
    n_nonfatal = 0;
  end
  always @(posedge aclk) begin
    if (report_fatal) n_fatal <= n_fatal + 1;
    if (report_nonfatal) n_nonfatal <= n_nonfatal + 1;
  end
endmodule : ues_rc_model

// file: verif/ues_severity_asserts.sv
// Purpose: port-level checks of the severity block reporting
// Assumes: events are one-cycle pulses, reports one cycle later
// Notes:   mask register is internal, so masked cases are judged by the bench
`timescale 1ns/100ps
module ues_severity_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Events and reports
  input wire logic [31:0] error_event,
  input wire logic        report_fatal,
  input wire logic        report_nonfatal,
  input wire logic [31:0] report_log
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_fatal_cause: assert property (
    report_fatal |-> ($past(error_event) & 32'h001F3030) != 32'h0) else $error("fatal no cause");
  a_nonfatal_cause: assert property (
    report_nonfatal |-> ($past(error_event) & 32'h001F3030) != 32'h0) else $error("nonfatal no cause");
  a_idle_quiet: assert property (
    error_event == 32'h0 |=> !report_fatal && !report_nonfatal) else $error("report without event");
  a_log_source: assert property (
    (report_log & ~$past(error_event)) == 32'h0) else $error("log bit without event");
  a_log_classes: assert property (
    (report_log & ~32'h001F3030) == 32'h0) else $error("log outside classes");
  a_bit0_silent: assert property (
    error_event == 32'h1 |=> report_log == 32'h0 && !report_fatal) else $error("bit 0 reported");
  a_log_reports: assert property (
    report_log != 32'h0 |-> report_fatal || report_nonfatal) else $error("log without report");
  a_fatal_pulse: assert property (
    report_fatal && error_event == 32'h0 |=> !report_fatal) else $error("fatal not a pulse");
endmodule : ues_severity_asserts

// file: verif/ues_tb_top.sv
// Purpose: self-checking bench for the severity register block
// Assumes: bready and rready held high, full write strobes
// Notes:   expected report counts kept here, compared with the model
`timescale 1ns/100ps
module uncorrectable_error_severity_tb_top;
  localparam logic [31:0] SEV_DEF = 32'h00062030;
  logic aclk = 1'b0, aresetn = 1'b0, cold_resetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, error_event = 32'h0, s_axi_rdata, report_log, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic report_fatal, report_nonfatal, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int err_count = 0, n_compared = 0, ef = 0, en = 0, n_fatal, n_nonfatal;
  always #5 aclk = ~aclk;
  ues_severity DUT (.aclk, .aresetn, .cold_resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .error_event, .report_fatal, .report_nonfatal,
    .report_log, .irq);
  ues_rc_model u_rc (.aclk, .report_fatal, .report_nonfatal, .n_fatal, .n_nonfatal);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && t < 50);
    chk({31'h0, s_axi_bvalid}, 32'h1);
    r = s_axi_bresp;
  endtask : axw
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && t < 50);
    chk({31'h0, s_axi_rvalid}, 32'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axr
  // One event pulse; exp is {fatal, nonfatal}
  task automatic ev(input int b, input logic [1:0] exp);
    error_event <= 32'h1 << b;
    @(posedge aclk);
    error_event <= 32'h0;
    #1;
    chk({30'h0, report_fatal, report_nonfatal}, {30'h0, exp});
    chk(report_log, (exp != 2'b00) ? 32'h1 << b : 32'h0);
    ef += exp[1];
    en += exp[0];
    @(posedge aclk);
  endtask : ev
  task automatic rst(input logic cold);
    aresetn <= 1'b0;
    cold_resetn <= !cold;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cold_resetn <= 1'b1;
    @(posedge aclk);
  endtask : rst
  task automatic irq_wait(input logic lvl);
    for (int i = 0; i < 6 && irq !== lvl; i++) @(posedge aclk);
    chk({31'h0, irq}, {31'h0, lvl});
  endtask : irq_wait
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #50us;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
  // Reset values, then each class once at its default severity
  task automatic t_defaults();
    int cls[9];
    cls = '{4, 5, 12, 13, 16, 17, 18, 19, 20};
    axr(12'h10C, rd, rs);
    chk(rd, SEV_DEF);
    foreach (cls[i]) ev(cls[i], {SEV_DEF[cls[i]], !SEV_DEF[cls[i]]});
    ev(0, 2'b00);
  endtask : t_defaults
  // All ones written, then all but bit 0 cleared, checked on classes 12 and 4
  task automatic t_write_sev();
    axw(12'h10C, 32'hFFFFFFFF, rs);
    chk({30'h0, rs}, 32'h0);
    axr(12'h10C, rd, rs);
    chk(rd, 32'h001F3031);
    ev(12, 2'b10);
    axw(12'h10C, 32'h00000001, rs);
    ev(4, 2'b01);
    ev(0, 2'b00);
  endtask : t_write_sev
  // Hot reset keeps the sticky bits, cold reset restores defaults
  task automatic t_sticky();
    rst(1'b0);
    axr(12'h10C, rd, rs);
    chk(rd, 32'h00000001);
    rst(1'b1);
    axr(12'h10C, rd, rs);
    chk(rd, SEV_DEF);
  endtask : t_sticky
  // Masked class neither reported nor logged
  task automatic t_mask();
    axw(12'h108, 32'h00000010, rs);
    axr(12'h108, rd, rs);
    chk(rd, 32'h00000010);
    ev(4, 2'b00);
  endtask : t_mask
  // Interrupt follows status and mask, status cleared by writing ones
  task automatic t_irq();
    axw(12'h124, 32'h00000003, rs);
    ev(5, 2'b10);
    irq_wait(1'b1);
    axw(12'h120, 32'h00000003, rs);
    irq_wait(1'b0);
    ev(12, 2'b01);
    irq_wait(1'b1);
    axr(12'h120, rd, rs);
    chk(rd, 32'h00000002);
    axw(12'h120, 32'h00000003, rs);
    irq_wait(1'b0);
    axw(12'h124, 32'h00000000, rs);
    ev(13, 2'b10);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    axr(12'h120, rd, rs);
    chk(rd, 32'h00000001);
  endtask : t_irq
  // Unmapped offsets answer an error and read zero
  task automatic t_unmapped();
    axr(12'h200, rd, rs);
    chk({rd[29:0], rs}, 32'h3);
    axw(12'h200, 32'hFFFFFFFF, rs);
    chk({30'h0, rs}, 32'h3);
  endtask : t_unmapped
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cold_resetn <= 1'b1;
    @(posedge aclk);
    t_defaults();
    t_write_sev();
    t_sticky();
    t_mask();
    t_irq();
    t_unmapped();
    chk(n_fatal, ef);
    chk(n_nonfatal, en);
    test_done();
  end
endmodule : uncorrectable_error_severity_tb_top
bind ues_severity ues_severity_asserts u_chk (.aclk, .aresetn, .error_event, .report_fatal,
  .report_nonfatal, .report_log);
